// ==== hdl/pps_map.svh ====
`ifndef PPS_MAP_SVH
`define PPS_MAP_SVH

// Configuration access: logical device and register offsets
`define PPS_LDEV_POWER      8'h0a
`define PPS_REG_SLOWCLK     8'hf0
`define PPS_REG_FAN         8'hf1
`define PPS_REG_WAKEMASK    8'hf2
`define PPS_REG_LED         8'hf3
`define PPS_REG_KBPINS      8'hf4

// Field positions
`define PPS_SLOWCLK_ABSENT  0
`define PPS_FAN_LEVEL_LO    0
`define PPS_FAN_INVERT_LO   2
`define PPS_LED_A_LO        0
`define PPS_LED_B_LO        2
`define PPS_KB_RESET_EN     0
`define PPS_KB_A20_EN       1

// Reset values
`define PPS_SLOWCLK_RESET   8'h00
`define PPS_FAN_RESET       8'h00
`define PPS_WAKEMASK_RESET  8'h00
`define PPS_LED_RESET       8'h00
`define PPS_KBPINS_RESET    8'h00
`define PPS_READ_NONE       8'h00

// Configuration port bases chosen by the strap
`define PPS_CFG_BASE_LOW    16'h002e
`define PPS_CFG_BASE_HIGH   16'h004e

// Timing: clock rate and slow clock rate in Hz
`define PPS_CLK_HZ          25000000
`define PPS_SLOW_HZ         32768
`define PPS_DIV_HALF        10'(`PPS_CLK_HZ / (2 * `PPS_SLOW_HZ))
`define PPS_DIV_ONE         10'h001
`define PPS_BLINK_ONE       15'h0001

// Strap capture waits for the pin synchroniser to fill
`define PPS_STRAP_SETTLE    2'h2
`define PPS_STRAP_STEP      2'h1

`endif

// ==== hdl/pps_pkg.sv ====
package pps_pkg;

   // One driven pin: level and output enable
   typedef struct packed {
      logic value;
      logic drive;
   } pps_pin_type;

   // LED behaviour per indicator
   typedef enum logic [1:0] {
      LED_OFF,
      LED_ON,
      LED_BLINK,
      LED_BLINK_INV
   } pps_led_mode_type;

   // Main supply state seen by the core
   typedef enum logic {
      MAIN_DOWN,
      MAIN_UP
   } pps_main_state_type;

endpackage : pps_pkg

// ==== hdl/pps_sync2.sv ====
`timescale 1ns/1ps
`default_nettype none

module pps_sync2 #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // Asynchronous in, synchronous out
   input  wire logic [WIDTH-1:0] d,
   output var  logic [WIDTH-1:0] q
);

   logic [WIDTH-1:0] stage1;

   always_ff @(posedge clk) begin
      if (rst) begin
         stage1 <= '0;
         q      <= '0;
      end else begin
         stage1 <= d;
         q      <= stage1;
      end
   end

endmodule : pps_sync2

`default_nettype wire

// ==== hdl/pps_power_plane.sv ====
// Functional notes
// - Main reset or hard reset: fans output low
// - Main supply lost: fans plain non-inverted output
// - Standby-only power: infrared transmit pins low
// - Infrared low until serial activate, then follow
// - Infrared function on general pin defaults 0
// - Strap low base 0x02e, high 0x04e
// - Keyboard-reset, gate-A20 pins start as inputs
// - Slow clock select bit at offset 0xf0
// - Bit 0 external clock, 1 internal derived
// - Power-good low: ignore all host accesses
// - Wake output and inputs work without power-good
// - Infrared and LED pins stay under control
// - Power-good enables infrared half-duplex timeout
// - Standby reset initialises wake and power registers
// - LED logic drives pins on standby power
// - Tachometer, blink, key-wake use slow clock
`timescale 1ns/1ps
`default_nettype none
`include "pps_map.svh"

module pps_power_plane
   import pps_pkg::*;
#(
   parameter int WAKE_W = 8
) (
   // Clock and standby power-on reset
   input  wire logic              clk,
   input  wire logic              rst,
   // Supply and reset pins
   input  wire logic              mainSupplyGood,
   input  wire logic              systemResetInN,
   input  wire logic              configBaseStrap,
   input  wire logic              slowClockIn,
   // Configuration access
   input  wire logic              cfgWrite,
   input  wire logic              cfgRead,
   input  wire logic [7:0]        cfgDevice,
   input  wire logic [7:0]        cfgAddr,
   input  wire logic [7:0]        cfgWriteData,
   output var  logic [7:0]        cfgReadData,
   output var  logic              cfgReadValid,
   output var  logic [15:0]       configBase,
   // Serial port and keyboard controller sources
   input  wire logic              secondSerialActivate,
   input  wire logic              secondSerialTransmit,
   input  wire logic              keyboardResetReq,
   input  wire logic              gateAddr20Req,
   // Wake inputs and output
   input  wire logic [WAKE_W-1:0] wakeInputs,
   output var  logic              wakeEventOutN,
   // Driven pins
   output var  pps_pin_type       fanDriveOutA,
   output var  pps_pin_type       fanDriveOutB,
   output var  logic              infraredTransmitOutA,
   output var  logic              infraredTransmitOutB,
   output var  logic              indicatorOutA,
   output var  logic              indicatorOutB,
   output var  pps_pin_type       keyboardResetOutN,
   output var  pps_pin_type       gateAddr20Out,
   // Status to other blocks
   output var  logic              hostInterfaceActive,
   output var  logic              irTimeoutEnable,
   output var  logic              slowTick
);

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers

   localparam int PIN_W = 4 + WAKE_W;
   logic [PIN_W-1:0] pinSync;

   pps_sync2 #(.WIDTH(PIN_W)) pinSyncer (
      .clk (clk),
      .rst (rst),
      .d   ({wakeInputs, slowClockIn, configBaseStrap, systemResetInN, mainSupplyGood}),
      .q   (pinSync)
   );

   wire logic              powerGood  = pinSync[0];
   wire logic              sysResetN  = pinSync[1];
   wire logic              strapLevel = pinSync[2];
   wire logic              slowExt    = pinSync[3];
   wire logic [WAKE_W-1:0] wakeSync   = pinSync[PIN_W-1:4];

   ////////////////////////////////////////////////////////////////////////////
   // Main supply state and reset events

   pps_main_state_type mainState;
   pps_main_state_type next_mainState;

   assign next_mainState = powerGood ? MAIN_UP : MAIN_DOWN;

   wire logic mainPor    = (mainState == MAIN_DOWN) && powerGood;
   wire logic mainLost   = (mainState == MAIN_UP) && !powerGood;
   wire logic hardReset  = powerGood && !sysResetN;
   wire logic mainReset  = mainPor || hardReset;

   always_ff @(posedge clk) begin
      if (rst) begin
         mainState <= MAIN_DOWN;
      end else begin
         mainState <= next_mainState;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Strap capture, once per standby reset, after the synchroniser has filled:
   // its reset zeros would otherwise always read as the low base

   logic       strapTaken;
   logic [1:0] strapAge;

   always_ff @(posedge clk) begin
      if (rst) begin
         strapTaken <= 1'b0;
         strapAge   <= '0;
         configBase <= `PPS_CFG_BASE_LOW;
      end else if (!strapTaken) begin
         if (strapAge == `PPS_STRAP_SETTLE) begin
            strapTaken <= 1'b1;
            configBase <= strapLevel ? `PPS_CFG_BASE_HIGH : `PPS_CFG_BASE_LOW;
         end else begin
            strapAge <= strapAge + `PPS_STRAP_STEP;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Configuration registers (all on standby power)

   logic [7:0] slowClkCfg;
   logic [7:0] fanCfg;
   logic [7:0] wakeMask;
   logic [7:0] ledCfg;
   logic [7:0] kbPinCfg;

   // Accesses are dropped whole while the supply is not good
   wire logic devHit    = (cfgDevice == `PPS_LDEV_POWER) && powerGood;
   wire logic wrSlowClk = cfgWrite && devHit && (cfgAddr == `PPS_REG_SLOWCLK);
   wire logic wrFan     = cfgWrite && devHit && (cfgAddr == `PPS_REG_FAN);
   wire logic wrWake    = cfgWrite && devHit && (cfgAddr == `PPS_REG_WAKEMASK);
   wire logic wrLed     = cfgWrite && devHit && (cfgAddr == `PPS_REG_LED);
   wire logic wrKb      = cfgWrite && devHit && (cfgAddr == `PPS_REG_KBPINS);

   wire logic [7:0] readMux =
      (cfgAddr == `PPS_REG_SLOWCLK)  ? slowClkCfg :
      (cfgAddr == `PPS_REG_FAN)      ? fanCfg     :
      (cfgAddr == `PPS_REG_WAKEMASK) ? wakeMask   :
      (cfgAddr == `PPS_REG_LED)      ? ledCfg     :
      (cfgAddr == `PPS_REG_KBPINS)   ? kbPinCfg   : `PPS_READ_NONE;

   // Fan: cleared by main or hard reset; invert dropped when main supply goes
   wire logic [7:0] invertMask = 8'h03 << `PPS_FAN_INVERT_LO;
   wire logic [7:0] next_fanCfg =
      mainReset ? `PPS_FAN_RESET :
      mainLost  ? (fanCfg & ~invertMask) :
      wrFan     ? cfgWriteData : fanCfg;

   always_ff @(posedge clk) begin
      if (rst) begin
         slowClkCfg <= `PPS_SLOWCLK_RESET;
         fanCfg     <= `PPS_FAN_RESET;
         wakeMask   <= `PPS_WAKEMASK_RESET;
         ledCfg     <= `PPS_LED_RESET;
         kbPinCfg   <= `PPS_KBPINS_RESET;
      end else begin
         fanCfg <= next_fanCfg;
         if (wrSlowClk) begin
            slowClkCfg <= cfgWriteData;
         end
         if (wrWake) begin
            wakeMask <= cfgWriteData;
         end
         if (wrLed) begin
            ledCfg <= cfgWriteData;
         end
         if (wrKb) begin
            kbPinCfg <= cfgWriteData;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cfgReadData  <= `PPS_READ_NONE;
         cfgReadValid <= 1'b0;
      end else begin
         cfgReadValid <= cfgRead && devHit;
         if (cfgRead && devHit) begin
            cfgReadData <= readMux;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Slow clock: external pin or divided-down main clock

   logic       slowExtPrev;
   logic [9:0] divCount;
   logic       slowInt;

   wire logic slowAbsent = slowClkCfg[`PPS_SLOWCLK_ABSENT];
   wire logic divWrap    = (divCount == `PPS_DIV_HALF - `PPS_DIV_ONE);
   wire logic extRise    = slowExt && !slowExtPrev;
   wire logic intRise    = divWrap && !slowInt;

   always_ff @(posedge clk) begin
      if (rst) begin
         slowExtPrev <= 1'b0;
         divCount    <= '0;
         slowInt     <= 1'b0;
         slowTick    <= 1'b0;
      end else begin
         slowExtPrev <= slowExt;
         divCount    <= divWrap ? '0 : divCount + `PPS_DIV_ONE;
         slowInt     <= divWrap ? !slowInt : slowInt;
         slowTick    <= slowAbsent ? intRise : extRise;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // LED blink, counted on slow ticks so it runs on standby power

   logic [14:0] blinkCount;

   wire logic blinkPhase = blinkCount[14];
   wire pps_led_mode_type ledModeA = pps_led_mode_type'(ledCfg[`PPS_LED_A_LO +: 2]);
   wire pps_led_mode_type ledModeB = pps_led_mode_type'(ledCfg[`PPS_LED_B_LO +: 2]);

   function automatic logic ledLevel(input pps_led_mode_type mode, input logic phase);
      unique case (mode)
         LED_OFF:       ledLevel = 1'b0;
         LED_ON:        ledLevel = 1'b1;
         LED_BLINK:     ledLevel = phase;
         LED_BLINK_INV: ledLevel = !phase;
      endcase
   endfunction : ledLevel

   always_ff @(posedge clk) begin
      if (rst) begin
         blinkCount    <= '0;
         indicatorOutA <= 1'b0;
         indicatorOutB <= 1'b0;
      end else begin
         if (slowTick) begin
            blinkCount <= blinkCount + `PPS_BLINK_ONE;
         end
         indicatorOutA <= ledLevel(ledModeA, blinkPhase);
         indicatorOutB <= ledLevel(ledModeB, blinkPhase);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Infrared transmit and fan pins

   logic irReleased;

   // Released only by the activate bit while main power is up
   wire logic next_irReleased = (mainReset || !powerGood) ? 1'b0 :
                                (irReleased || secondSerialActivate);
   wire logic irLevel = irReleased && secondSerialTransmit;

   wire logic [1:0] fanLevel  = fanCfg[`PPS_FAN_LEVEL_LO +: 2];
   wire logic [1:0] fanInvert = fanCfg[`PPS_FAN_INVERT_LO +: 2];

   always_ff @(posedge clk) begin
      if (rst) begin
         irReleased           <= 1'b0;
         infraredTransmitOutA <= 1'b0;
         infraredTransmitOutB <= 1'b0;
         fanDriveOutA         <= '{value: 1'b0, drive: 1'b1};
         fanDriveOutB         <= '{value: 1'b0, drive: 1'b1};
         irTimeoutEnable      <= 1'b0;
         hostInterfaceActive  <= 1'b0;
      end else begin
         irReleased           <= next_irReleased;
         infraredTransmitOutA <= irLevel;
         infraredTransmitOutB <= irLevel;
         fanDriveOutA         <= '{value: fanLevel[0] ^ fanInvert[0], drive: 1'b1};
         fanDriveOutB         <= '{value: fanLevel[1] ^ fanInvert[1], drive: 1'b1};
         irTimeoutEnable      <= powerGood;
         // Host reset is expected to follow the bus reset protocol
         hostInterfaceActive  <= powerGood && sysResetN;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Keyboard-reset and gate-A20 pins, and the wake output

   always_ff @(posedge clk) begin
      if (rst) begin
         keyboardResetOutN <= '{value: 1'b1, drive: 1'b0};
         gateAddr20Out     <= '{value: 1'b0, drive: 1'b0};
         wakeEventOutN     <= 1'b1;
      end else begin
         keyboardResetOutN <= '{value: !keyboardResetReq,
                                drive: kbPinCfg[`PPS_KB_RESET_EN] && powerGood};
         gateAddr20Out     <= '{value: gateAddr20Req,
                                drive: kbPinCfg[`PPS_KB_A20_EN] && powerGood};
         // Not gated by power-good, so wakes work on standby power
         wakeEventOutN     <= !(|(wakeSync & wakeMask[WAKE_W-1:0]));
      end
   end

endmodule : pps_power_plane

`default_nettype wire

// ==== verif/pps_power_plane_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none

module pps_power_plane_monitor
   import pps_pkg::*;
#(
   parameter int WAKE_W = 8
) (
   // Clock and reset
   input wire logic              clk,
   input wire logic              rst,
   // Inputs watched
   input wire logic              mainSupplyGood,
   input wire logic              cfgRead,
   input wire logic [7:0]        cfgDevice,
   input wire logic [WAKE_W-1:0] wakeInputs,
   // Outputs watched
   input wire logic              cfgReadValid,
   input wire logic [15:0]       configBase,
   input wire logic              wakeEventOutN,
   input wire pps_pin_type       fanDriveOutA,
   input wire pps_pin_type       fanDriveOutB,
   input wire logic              infraredTransmitOutA,
   input wire logic              infraredTransmitOutB,
   input wire pps_pin_type       keyboardResetOutN,
   input wire pps_pin_type       gateAddr20Out,
   input wire logic              hostInterfaceActive,
   input wire logic              irTimeoutEnable,
   input wire logic              slowTick
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   property p_fan_rst;
      $fell(rst) |-> !fanDriveOutA.value && !fanDriveOutB.value;
   endproperty
   a_fan_rst: assert property (p_fan_rst) else $error("fans not low after reset");
   property p_fan_drv;
      fanDriveOutA.drive && fanDriveOutB.drive;
   endproperty
   a_fan_drv: assert property (p_fan_drv) else $error("fan pin not driven");
   property p_kb_in;
      $fell(rst) |-> !keyboardResetOutN.drive && !gateAddr20Out.drive;
   endproperty
   a_kb_in: assert property (p_kb_in) else $error("keyboard pins driven after reset");
   property p_base;
      configBase == 16'h002e || configBase == 16'h004e;
   endproperty
   a_base: assert property (p_base) else $error("bad configuration base");
   property p_ans;
      cfgReadValid |-> $past(cfgRead) && $past(cfgDevice) == 8'h0a;
   endproperty
   a_ans: assert property (p_ans) else $error("answer without read");
   property p_ir_low;
      (!irTimeoutEnable)[*3] |-> !infraredTransmitOutA && !infraredTransmitOutB;
   endproperty
   a_ir_low: assert property (p_ir_low) else $error("infrared driven without power");
   property p_wake;
      (wakeInputs == '0)[*4] |-> wakeEventOutN;
   endproperty
   a_wake: assert property (p_wake) else $error("wake without source");
   property p_tmo;
      irTimeoutEnable |-> $past(mainSupplyGood, 3);
   endproperty
   a_tmo: assert property (p_tmo) else $error("timeout enabled without power");
   property p_host;
      hostInterfaceActive |-> irTimeoutEnable;
   endproperty
   a_host: assert property (p_host) else $error("host active without power");
   property p_tick;
      slowTick |=> !slowTick;
   endproperty
   a_tick: assert property (p_tick) else $error("tick longer than one cycle");

   c_read: cover property (cfgReadValid);
   c_wake: cover property ($fell(wakeEventOutN));
   c_tick: cover property (slowTick);
   c_down: cover property ($fell(hostInterfaceActive));
endmodule : pps_power_plane_monitor

bind pps_power_plane pps_power_plane_monitor #(.WAKE_W(WAKE_W)) u_mon (
   .clk, .rst, .mainSupplyGood, .cfgRead, .cfgDevice, .wakeInputs, .cfgReadValid,
   .configBase, .wakeEventOutN, .fanDriveOutA, .fanDriveOutB, .infraredTransmitOutA,
   .infraredTransmitOutB, .keyboardResetOutN, .gateAddr20Out, .hostInterfaceActive,
   .irTimeoutEnable, .slowTick
);

`default_nettype wire

// ==== verif/pps_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module pps_host_model (
   // Clock
   input  wire logic       clk,
   // Configuration access and system reset
   output var  logic       cfgWrite,
   output var  logic       cfgRead,
   output var  logic [7:0] cfgDevice,
   output var  logic [7:0] cfgAddr,
   output var  logic [7:0] cfgWriteData,
   output var  logic       systemResetInN
);
   initial begin
      {cfgWrite, cfgRead, cfgDevice, cfgAddr, cfgWriteData} = '0;
      systemResetInN = 1'b1;
   end

   // One strobe cycle; released fields show the inverse, not stale data
   task automatic acc(input logic w, input logic [7:0] dev, a, d);
      @(negedge clk);
      {cfgWrite, cfgRead, cfgDevice, cfgAddr, cfgWriteData} = {w, !w, dev, a, d};
      @(negedge clk);
      {cfgWrite, cfgRead, cfgDevice, cfgAddr, cfgWriteData} = {2'b00, ~dev, ~a, ~d};
   endtask : acc

   task automatic hard_reset(input int n);
      @(negedge clk);
      systemResetInN = 1'b0;
      repeat (n) @(negedge clk);
      systemResetInN = 1'b1;
   endtask : hard_reset
endmodule : pps_host_model

`default_nettype wire

// ==== verif/test_pps_power_plane.sv ====
`timescale 1ns/1ps
`default_nettype none

module test_pps_power_plane;
   import pps_pkg::*;
   logic clk = 0, rst = 1, mainSupplyGood = 0, configBaseStrap = 0, slowClockIn = 0;
   logic secondSerialActivate = 0, secondSerialTransmit = 0, keyboardResetReq = 0, gateAddr20Req = 0;
   logic [7:0] wakeInputs = 8'h00, cfgDevice, cfgAddr, cfgWriteData, cfgReadData, a;
   logic cfgWrite, cfgRead, systemResetInN, cfgReadValid, wakeEventOutN, slowTick;
   logic infraredTransmitOutA, infraredTransmitOutB, indicatorOutA, indicatorOutB;
   logic hostInterfaceActive, irTimeoutEnable;
   logic [15:0] configBase;
   pps_pin_type fanDriveOutA, fanDriveOutB, keyboardResetOutN, gateAddr20Out;
   int n_fail = 0, compares = 0, t;
   logic [7:0] notes[$];

   always #20 clk = ~clk;

   pps_host_model host (.clk, .cfgWrite, .cfgRead, .cfgDevice, .cfgAddr, .cfgWriteData, .systemResetInN);
   pps_power_plane dut (.clk, .rst, .mainSupplyGood, .systemResetInN, .configBaseStrap, .slowClockIn,
      .cfgWrite, .cfgRead, .cfgDevice, .cfgAddr, .cfgWriteData, .cfgReadData, .cfgReadValid,
      .configBase, .secondSerialActivate, .secondSerialTransmit, .keyboardResetReq, .gateAddr20Req,
      .wakeInputs, .wakeEventOutN, .fanDriveOutA, .fanDriveOutB, .infraredTransmitOutA,
      .infraredTransmitOutB, .indicatorOutA, .indicatorOutB, .keyboardResetOutN, .gateAddr20Out,
      .hostInterfaceActive, .irTimeoutEnable, .slowTick);

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] got, exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task automatic chkRd(input logic [7:0] got, exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t read %h exp %h", $time, got, exp);
      end
   endtask : chkRd

   task automatic conclude;
      if (n_fail == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : conclude

   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask : cyc

   task automatic wr(input logic [7:0] ad, d);
      host.acc(1'b1, 8'h0a, ad, d);
   endtask : wr

   task automatic rd(input logic [7:0] ad, e);
      notes.push_back(e);
      host.acc(1'b0, 8'h0a, ad, 8'h00);
   endtask : rd

   task automatic power(input logic v);
      mainSupplyGood = v;
      cyc(6);
   endtask : power

   task automatic ticks(input int n);
      t = 0;
      repeat (n) begin
         @(negedge clk);
         t += int'(slowTick === 1'b1);
      end
   endtask : ticks

   ////////////////////////////////////////////////////////////////////////////////
   // An answer with no note pending is itself a mismatch
   always @(posedge clk)
      if (!rst && cfgReadValid === 1'b1) begin
         if (notes.size() == 0)
            chk(16'h0001, 16'h0000);
         else
            chkRd(cfgReadData, notes.pop_front());
      end

   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      conclude();
   end

   initial begin
      void'($urandom(32'h87b8));
      for (int s = 0; s < 2; s++) begin
         configBaseStrap = s[0];
         rst = 1;
         cyc(12);
         rst = 0;
         cyc(4);
         chk(configBase, s ? 16'h004e : 16'h002e);
      end
      chk({fanDriveOutA, fanDriveOutB}, 16'h0005);
      chk({keyboardResetOutN.drive, gateAddr20Out.drive}, 16'h0000);
      host.acc(1'b0, 8'h0a, 8'hf0, 8'h00);
      cyc(3);
      chk(hostInterfaceActive, 16'h0000);
      power(1);
      chk({hostInterfaceActive, irTimeoutEnable}, 16'h0003);
      secondSerialTransmit = 1;
      cyc(4);
      chk({infraredTransmitOutA, infraredTransmitOutB}, 16'h0000);
      rd(8'hf0, 8'h00);
      wr(8'hf0, 8'h01);
      rd(8'hf0, 8'h01);
      host.acc(1'b0, 8'h05, 8'hf0, 8'h00);
      a = 8'($urandom_range(8'hef));
      wr(a, 8'($urandom));
      rd(a, 8'h00);
      wr(8'hf0, 8'h00);
      wr(8'hf1, 8'h03);
      cyc(3);
      chk({fanDriveOutA, fanDriveOutB}, 16'h000f);
      host.hard_reset(3);
      cyc(5);
      chk({fanDriveOutA, fanDriveOutB}, 16'h0005);
      secondSerialActivate = 1;
      repeat (8) begin
         secondSerialTransmit = 1'($urandom);
         cyc(3);
         chk({infraredTransmitOutA, infraredTransmitOutB}, {2{secondSerialTransmit}});
      end
      secondSerialTransmit = 1;
      wr(8'hf1, 8'h0c);
      wr(8'hf2, 8'h01);
      wr(8'hf3, 8'h0d);
      cyc(3);
      chk({fanDriveOutA, fanDriveOutB, indicatorOutA, indicatorOutB}, 16'h003f);
      power(0);
      chk({fanDriveOutA, fanDriveOutB, indicatorOutA, indicatorOutB}, 16'h0017);
      chk({infraredTransmitOutA, infraredTransmitOutB, hostInterfaceActive}, 16'h0000);
      wakeInputs = 8'h01;
      cyc(4);
      chk(wakeEventOutN, 16'h0000);
      wakeInputs = 8'h00;
      cyc(4);
      chk(wakeEventOutN, 16'h0001);
      power(1);
      chk({fanDriveOutA, fanDriveOutB}, 16'h0005);
      wr(8'hf3, 8'h06);
      cyc(2);
      chk({indicatorOutA, indicatorOutB}, 16'h0001);
      wr(8'hf4, 8'h03);
      {keyboardResetReq, gateAddr20Req} = 2'b11;
      cyc(3);
      chk({keyboardResetOutN, gateAddr20Out}, 16'h0007);
      fork
         repeat (3) begin
            slowClockIn = 1;
            cyc(10);
            slowClockIn = 0;
            cyc(10);
         end
         ticks(70);
      join
      chk(t[15:0], 16'h0003);
      wr(8'hf0, 8'h01);
      cyc(800);
      ticks(1524);
      chk(t[15:0], 16'h0002);
      for (int i = 0; i < 20 && notes.size() > 0; i++)
         cyc(1);
      chk(notes.size(), 16'h0000);
      conclude();
   end
endmodule : test_pps_power_plane

`default_nettype wire
